// file: pkg/mpg_defs.vh
// register map, field positions and reset values of the three-port gpio block
// included by the gpio top and by bench files; definitions only
`ifndef MPG_DEFS_VH
`define MPG_DEFS_VH

// ****************************************************************
// register word indices on the avalon address lines
// ****************************************************************
`define MPG_IDX_OD_LATCH 8'h01
`define MPG_IDX_TS_LATCH 8'h02
`define MPG_IDX_TH_LATCH 8'h03
`define MPG_IDX_OD_DIR 8'h04
`define MPG_IDX_TS_DIR 8'h05
`define MPG_IDX_TH_DIR 8'h06
`define MPG_IDX_OPTION2 8'h07
`define MPG_IDX_TIMER_CFG 8'h08
`define MPG_IDX_COUNT 8'h09

// ****************************************************************
// widths and reset values
// ****************************************************************
`define MPG_W8 8
`define MPG_W4 4
`define MPG_DIR8_RST 8'h00
`define MPG_DIR4_RST 4'h0
`define MPG_OPT2_RST 3'h0
`define MPG_TCFG_RST 11'h000
`define MPG_ZERO32 32'h00000000

// ****************************************************************
// field positions
// ****************************************************************
// option 2: bit0 disables pullup on pin 2, bit1 pin 3, bit2 pin 7
`define MPG_OPT2_W 3
`define MPG_PU_PIN2 2
`define MPG_PU_PIN3 3
`define MPG_PU_PIN7 7
`define MPG_OPT2_B_PIN2 0
`define MPG_OPT2_B_PIN3 1
`define MPG_OPT2_B_PIN7 2
// timer config: [1:0] ch0 mode, [3:2] ch0 edge/level, [5:4] ch1 mode,
// [7:6] ch1 edge/level, [10:8] prescaler select
`define MPG_TCFG_W 11
`define MPG_CH0_MS 1:0
`define MPG_CH0_ELS 3:2
`define MPG_CH1_MS 5:4
`define MPG_CH1_ELS 7:6
`define MPG_PS 10:8
`define MPG_MS_PORT 2'h0
`define MPG_ELS_OFF 2'h0
`define MPG_PS_EXTCLK 3'h7

`endif

// file: core/mpg_sync.v
// two-flop synchroniser for a bus of pin levels
// assumes one clock domain, async active-low reset
`timescale 1ns/1ps
module mpg_sync #(
    parameter W = 8
) (
    input wire clk,
    input wire rstn,
    input wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    // first stage is read only by the second stage
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end
    assign q = sync_r;
endmodule // mpg_sync

// file: core/mpg_gpio.v
// three-port gpio: open-drain 8-bit port, 4-bit timer-shared port,
// 8-bit third port with pullups on pins 2, 3 and 7
// assumes an avalon-mm master on clk; pins outside are resolved by the
// bench from out/oe pairs (oe low means driving)
`timescale 1ns/1ps
`include "mpg_defs.vh"
module mpg_gpio (
    input wire clk,
    input wire rstn,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    output reg avs_response_err,
    input wire [7:0] od_pin_in,
    output wire [7:0] od_pin_out,
    output wire [7:0] od_pin_oe_n,
    input wire [3:0] ts_pin_in,
    output wire [3:0] ts_pin_out,
    output wire [3:0] ts_pin_oe_n,
    input wire [7:0] th_pin_in,
    output wire [7:0] th_pin_out,
    output wire [7:0] th_pin_oe_n,
    output wire [7:0] th_pullup_en,
    input wire [1:0] timer_ch0_out,
    input wire [1:0] timer_ch1_out,
    output wire timer_channel0_pin,
    output wire timer_channel1_pin,
    output wire external_timer_clock_pin
);
    // ****************************************************************
    // helper
    // ****************************************************************
    // read mux: latch where output, synchronised pin where input
    function [7:0] port_view;
        input [7:0] dir;
        input [7:0] latch;
        input [7:0] pin;
        port_view = (dir & latch) | (~dir & pin);
    endfunction

    // index match; shared by every write strobe
    function hit;
        input [7:0] at;
        input [7:0] want;
        hit = (at == want);
    endfunction

    // a channel keeps its pin only with both mode and edge/level nonzero;
    // a channel left in a half-set state therefore stays plain port logic
    function chan_owns;
        input [1:0] mode;
        input [1:0] els;
        chan_owns = (mode != `MPG_MS_PORT) && (els != `MPG_ELS_OFF);
    endfunction

    // pullup request of one third-port pin: on unless its option bit is set
    function pull_on;
        input [`MPG_OPT2_W-1:0] opt;
        input integer pin;
        case (pin)
            `MPG_PU_PIN2: pull_on = ~opt[`MPG_OPT2_B_PIN2];
            `MPG_PU_PIN3: pull_on = ~opt[`MPG_OPT2_B_PIN3];
            `MPG_PU_PIN7: pull_on = ~opt[`MPG_OPT2_B_PIN7];
            default: pull_on = 1'b0;
        endcase
    endfunction

    // ****************************************************************
    // registers
    // ****************************************************************
    reg [7:0] open_drain_port_latch_r;
    reg [3:0] timer_shared_port_latch_r;
    reg [7:0] third_port_latch_r;
    reg [7:0] open_drain_port_direction_r;
    reg [3:0] timer_shared_port_direction_r;
    reg [7:0] third_port_direction_r;
    reg [`MPG_OPT2_W-1:0] port_option_control_2_r;
    reg [`MPG_TCFG_W-1:0] timer_cfg_r;
    reg rd_pend_r;
    reg [31:0] rdata_nxt;
    reg err_nxt;

    wire [7:0] od_sync;
    wire [3:0] ts_sync;
    wire [7:0] th_sync;
    wire [7:0] wbyte;
    wire wr_en;
    wire [7:0] idx;

    assign wbyte = avs_writedata[7:0];
    assign wr_en = avs_write & avs_byteenable[0];
    assign idx = {4'h0, avs_address};

    // ****************************************************************
    // write strobes
    // ****************************************************************
    wire wr_od_latch;
    wire wr_ts_latch;
    wire wr_th_latch;
    wire wr_od_dir;
    wire wr_ts_dir;
    wire wr_th_dir;
    wire wr_opt2;
    wire wr_tcfg;

    // an unmapped index matches no strobe, so such a write is dropped
    assign wr_od_latch = wr_en & hit(idx, `MPG_IDX_OD_LATCH);
    assign wr_ts_latch = wr_en & hit(idx, `MPG_IDX_TS_LATCH);
    assign wr_th_latch = wr_en & hit(idx, `MPG_IDX_TH_LATCH);
    assign wr_od_dir = wr_en & hit(idx, `MPG_IDX_OD_DIR);
    assign wr_ts_dir = wr_en & hit(idx, `MPG_IDX_TS_DIR);
    assign wr_th_dir = wr_en & hit(idx, `MPG_IDX_TH_DIR);
    assign wr_opt2 = wr_en & hit(idx, `MPG_IDX_OPTION2);
    assign wr_tcfg = wr_en & hit(idx, `MPG_IDX_TIMER_CFG);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    mpg_sync #(.W(`MPG_W8)) u_sync_od (
        .clk(clk),
        .rstn(rstn),
        .d(od_pin_in),
        .q(od_sync)
    );
    mpg_sync #(.W(`MPG_W4)) u_sync_ts (
        .clk(clk),
        .rstn(rstn),
        .d(ts_pin_in),
        .q(ts_sync)
    );
    mpg_sync #(.W(`MPG_W8)) u_sync_th (
        .clk(clk),
        .rstn(rstn),
        .d(th_pin_in),
        .q(th_sync)
    );

    // ****************************************************************
    // read views per port
    // ****************************************************************
    wire [7:0] od_view;
    wire [7:0] ts_view;
    wire [7:0] th_view;

    assign od_view = port_view(open_drain_port_direction_r,
        open_drain_port_latch_r, od_sync);
    // direction still picks the read source on timer-owned pins
    assign ts_view = port_view({4'h0, timer_shared_port_direction_r},
        {4'h0, timer_shared_port_latch_r}, {4'h0, ts_sync});
    assign th_view = port_view(third_port_direction_r,
        third_port_latch_r, th_sync);

    // ****************************************************************
    // control registers
    // ****************************************************************
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            open_drain_port_direction_r <= `MPG_DIR8_RST;
            third_port_direction_r <= `MPG_DIR8_RST;
            timer_shared_port_direction_r <= `MPG_DIR4_RST;
            port_option_control_2_r <= `MPG_OPT2_RST;
            timer_cfg_r <= `MPG_TCFG_RST;
        end else begin
            if (wr_od_dir) begin
                open_drain_port_direction_r <= wbyte;
            end
            if (wr_ts_dir) begin
                timer_shared_port_direction_r <= wbyte[`MPG_W4-1:0];
            end
            if (wr_th_dir) begin
                third_port_direction_r <= wbyte;
            end
            if (wr_opt2) begin
                port_option_control_2_r <= wbyte[`MPG_OPT2_W-1:0];
            end
            if (wr_tcfg) begin
                timer_cfg_r <= avs_writedata[`MPG_TCFG_W-1:0];
            end
        end
    end

    // latches have no reset so their content survives it
    always @(posedge clk) begin
        // written whatever the direction bits say
        if (wr_od_latch) begin
            open_drain_port_latch_r <= wbyte;
        end
        if (wr_ts_latch) begin
            timer_shared_port_latch_r <= wbyte[`MPG_W4-1:0];
        end
        if (wr_th_latch) begin
            third_port_latch_r <= wbyte;
        end
    end

    // ****************************************************************
    // avalon slave: writes take one cycle, reads wait one cycle
    // ****************************************************************
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_pend_r <= 1'b0;
        end else begin
            rd_pend_r <= avs_read & ~rd_pend_r;
        end
    end
    assign avs_waitrequest = avs_read & ~rd_pend_r;

    always @* begin
        rdata_nxt = `MPG_ZERO32;
        err_nxt = 1'b0;
        case (idx)
            `MPG_IDX_OD_LATCH: rdata_nxt[7:0] = od_view;
            `MPG_IDX_TS_LATCH: rdata_nxt[7:0] = ts_view;
            `MPG_IDX_TH_LATCH: rdata_nxt[7:0] = th_view;
            `MPG_IDX_OD_DIR: rdata_nxt[7:0] = open_drain_port_direction_r;
            `MPG_IDX_TS_DIR: rdata_nxt[3:0] = timer_shared_port_direction_r;
            `MPG_IDX_TH_DIR: rdata_nxt[7:0] = third_port_direction_r;
            `MPG_IDX_OPTION2: rdata_nxt[`MPG_OPT2_W-1:0] = port_option_control_2_r;
            `MPG_IDX_TIMER_CFG: rdata_nxt[`MPG_TCFG_W-1:0] = timer_cfg_r;
            default: err_nxt = 1'b1;
        endcase
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            avs_readdata <= `MPG_ZERO32;
            avs_response_err <= 1'b0;
        end else if (avs_read & ~rd_pend_r) begin
            avs_readdata <= rdata_nxt;
            avs_response_err <= err_nxt;
        end
    end

    // ****************************************************************
    // open-drain port
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < `MPG_W8; gi = gi + 1) begin : g_od
            // drive only a low; a high latch releases the line
            assign od_pin_out[gi] = 1'b0;
            assign od_pin_oe_n[gi] = ~(open_drain_port_direction_r[gi]
                & ~open_drain_port_latch_r[gi]);
        end
    endgenerate

    // ****************************************************************
    // timer-shared port
    // ****************************************************************
    wire ch0_timer;
    wire ch1_timer;
    wire clk_timer;
    wire [3:0] ts_dir_eff;
    wire [3:0] ts_val;

    // channel owns pin when mode nonzero and edge/level select not off
    assign ch0_timer = chan_owns(timer_cfg_r[`MPG_CH0_MS],
        timer_cfg_r[`MPG_CH0_ELS]);
    assign ch1_timer = chan_owns(timer_cfg_r[`MPG_CH1_MS],
        timer_cfg_r[`MPG_CH1_ELS]);
    assign clk_timer = (timer_cfg_r[`MPG_PS] == `MPG_PS_EXTCLK);

    // the drive of timer-owned pins ignores the direction bits
    // pin 1 under the external clock is held as an input, the clock never drives
    wire [3:0] ts_owned;
    wire [3:0] ts_tdir;
    wire [3:0] ts_tval;

    assign ts_owned = {1'b0, ch1_timer, clk_timer, ch0_timer};
    assign ts_tdir = {1'b0, timer_ch1_out[1], 1'b0, timer_ch0_out[1]};
    assign ts_tval = {1'b0, timer_ch1_out[0], 1'b0, timer_ch0_out[0]};

    generate
        for (gi = 0; gi < `MPG_W4; gi = gi + 1) begin : g_ts
            assign ts_dir_eff[gi] = ts_owned[gi] ? ts_tdir[gi]
                : timer_shared_port_direction_r[gi];
            assign ts_val[gi] = ts_owned[gi] ? ts_tval[gi]
                : timer_shared_port_latch_r[gi];
        end
    endgenerate
    assign ts_pin_out = ts_val;
    assign ts_pin_oe_n = ~ts_dir_eff;
    assign timer_channel0_pin = ts_sync[0];
    assign timer_channel1_pin = ts_sync[2];
    assign external_timer_clock_pin = clk_timer & ts_sync[1];

    // ****************************************************************
    // third port
    // ****************************************************************
    // pullups default on; a set option bit turns one off, pins without one stay 0
    generate
        for (gi = 0; gi < `MPG_W8; gi = gi + 1) begin : g_th
            assign th_pin_out[gi] = third_port_latch_r[gi];
            assign th_pin_oe_n[gi] = ~third_port_direction_r[gi];
            assign th_pullup_en[gi] = pull_on(port_option_control_2_r, gi);
        end
    endgenerate
endmodule // mpg_gpio

// file: sim/mpg_checker.sv
// port-level assertions for the three-port gpio
// assumes one clock, async active-low reset; bound to every gpio instance
`timescale 1ns/1ps
module mpg_checker (
    input wire clk,
    input wire rstn,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire avs_response_err,
    input wire [7:0] od_pin_out,
    input wire [7:0] od_pin_oe_n,
    input wire [3:0] ts_pin_in,
    input wire [3:0] ts_pin_oe_n,
    input wire [7:0] th_pin_oe_n,
    input wire [7:0] th_pullup_en,
    input wire timer_channel0_pin,
    input wire timer_channel1_pin,
    input wire external_timer_clock_pin
);
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    od_low_only_a: assert property (od_pin_out == 8'h00) else $error("od high");
    rst_inputs_a: assert property ($rose(rstn) |-> &{od_pin_oe_n, ts_pin_oe_n, th_pin_oe_n})
        else $error("pin driven after reset");
    pu_rst_on_a: assert property ($rose(rstn) |-> th_pullup_en == 8'h8C)
        else $error("pullups off after reset");
    pu_mask_a: assert property ((th_pullup_en & 8'h73) == 8'h00) else $error("bad pullup");
    // sync flops are reset, so only look once two clean edges have passed
    ch_sync_a: assert property ($past(rstn, 2) && $past(rstn) |->
        {timer_channel1_pin, timer_channel0_pin} == $past({ts_pin_in[2], ts_pin_in[0]}, 2))
        else $error("channel pin not synced");
    clk_sync_a: assert property (external_timer_clock_pin |-> $past(ts_pin_in[1], 2))
        else $error("timer clock not synced");
    wr_nowait_a: assert property (avs_write |-> !avs_waitrequest) else $error("write waited");
    rd_first_a: assert property (avs_read && !$past(avs_read) |-> avs_waitrequest)
        else $error("read not held");
    rd_answer_a: assert property (avs_read |-> ##[0:1] !avs_waitrequest) else $error("read hang");
    bad_addr_a: assert property (avs_read && !avs_waitrequest &&
        (avs_address == 4'h0 || avs_address > 4'h8) |-> avs_response_err && avs_readdata == 32'h0)
        else $error("unmapped read");
    byte_read_a: assert property (avs_read && !avs_waitrequest && avs_address inside {[1:7]}
        |-> !avs_response_err && avs_readdata[31:8] == 24'h0) else $error("upper bits set");
endmodule // mpg_checker

bind mpg_gpio mpg_checker chk_i (.*);

// file: sim/mpg_pins.sv
// pin model around the gpio: outside drivers, pull-ups, floating lines
// assumes out/oe_n pairs from the gpio, oe_n low meaning the gpio drives
`timescale 1ns/1ps
module mpg_pins (
    input wire [7:0] od_pin_oe_n,
    input wire [3:0] ts_pin_out,
    input wire [3:0] ts_pin_oe_n,
    input wire [7:0] th_pin_out,
    input wire [7:0] th_pin_oe_n,
    input wire [7:0] th_pullup_en,
    input wire [7:0] ext_od,
    input wire [3:0] ext_ts,
    input wire [7:0] ext_th,
    input wire [7:0] ext_th_en,
    output wire [7:0] od_pin_in,
    output wire [3:0] ts_pin_in,
    output wire [7:0] th_pin_in
);
    // ****************************************************************
    // wire levels
    // ****************************************************************
    // a released open-drain line follows the outside party
    assign od_pin_in = od_pin_oe_n & ext_od;
    assign ts_pin_in = (~ts_pin_oe_n & ts_pin_out) | (ts_pin_oe_n & ext_ts);
    // a line nobody holds reads high with its pullup on, else the inverse of the outside value, so a floating line never reads as x
    assign th_pin_in = (~th_pin_oe_n & th_pin_out) | (th_pin_oe_n & ((ext_th_en & ext_th) |
        (~ext_th_en & (th_pullup_en | ~ext_th))));
endmodule // mpg_pins

// file: sim/tb_top.sv
// self-checking bench for the three-port gpio
// assumes the pin model beside the dut and the checker bound to it
`timescale 1ns/1ps
`include "mpg_defs.vh"
module tb_top;
    logic clk = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0, ext_ts = 4'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [1:0] timer_ch0_out = 2'h0, timer_ch1_out = 2'h0;
    logic [7:0] ext_od = 8'h00, ext_th = 8'h00, ext_th_en = 8'h00;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, avs_response_err;
    wire timer_channel0_pin, timer_channel1_pin, external_timer_clock_pin;
    wire [7:0] od_pin_in, od_pin_out, od_pin_oe_n, th_pin_in, th_pin_out, th_pin_oe_n, th_pullup_en;
    wire [3:0] ts_pin_in, ts_pin_out, ts_pin_oe_n;
    int miscompares = 0, compares = 0;
    initial forever #5 clk = ~clk;
    mpg_gpio dut (.*);
    mpg_pins pins (.*);
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task wrr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b = 4'h1);
        @(posedge clk);
        avs_address <= a[3:0];
        avs_writedata <= d;
        avs_byteenable <= b;
        avs_write <= 1'b1;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        avs_write <= 1'b0;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] e, input logic ee = 1'b0);
        @(posedge clk);
        avs_address <= a[3:0];
        avs_read <= 1'b1;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        chk(avs_readdata, e);
        chk(32'(avs_response_err), 32'(ee));
        avs_read <= 1'b0;
    endtask
    // lets writes land and the pin synchroniser catch up
    task idle;
        repeat (4) @(posedge clk);
    endtask
    task do_reset;
        rstn <= 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task t_reset;
        rdc(`MPG_IDX_OD_DIR, 32'h0);
        rdc(`MPG_IDX_TS_DIR, 32'h0);
        rdc(`MPG_IDX_TH_DIR, 32'h0);
        chk(32'(th_pullup_en), 32'h8C);
        $display("t_reset done");
    endtask
    task t_od;
        ext_od <= 8'hC3;
        wrr(`MPG_IDX_OD_LATCH, 32'h5A);
        wrr(`MPG_IDX_OD_DIR, 32'h0F);
        idle;
        chk(32'(od_pin_oe_n), 32'hFA);
        rdc(`MPG_IDX_OD_LATCH, 32'hCA);
        wrr(`MPG_IDX_OD_LATCH, 32'hFF);
        idle;
        rdc(`MPG_IDX_OD_LATCH, 32'hCF);
        chk(32'(od_pin_oe_n), 32'hFF);
        $display("t_od done");
    endtask
    task t_ts;
        ext_ts <= 4'h6;
        wrr(`MPG_IDX_TS_LATCH, 32'h9);
        wrr(`MPG_IDX_TS_DIR, 32'h3);
        idle;
        chk(32'(ts_pin_oe_n), 32'hC);
        rdc(`MPG_IDX_TS_LATCH, 32'h5);
        timer_ch0_out <= 2'h3;
        ext_ts <= 4'h2;
        wrr(`MPG_IDX_TS_DIR, 32'h0);
        wrr(`MPG_IDX_TIMER_CFG, 32'h705);
        idle;
        chk(32'(ts_pin_oe_n), 32'hE);
        chk(32'({timer_channel0_pin, external_timer_clock_pin}), 32'h3);
        rdc(`MPG_IDX_TS_LATCH, 32'h3);
        timer_ch0_out <= 2'h0;
        wrr(`MPG_IDX_TS_DIR, 32'h1);
        idle;
        chk(32'(ts_pin_oe_n), 32'hF);
        rdc(`MPG_IDX_TS_LATCH, 32'h3);
        rdc(`MPG_IDX_TIMER_CFG, 32'h705);
        wrr(`MPG_IDX_TIMER_CFG, 32'h0);
        idle;
        chk(32'({ts_pin_oe_n, external_timer_clock_pin}), 32'h1C);
        $display("t_ts done");
    endtask
    task t_th;
        ext_th_en <= 8'h73;
        wrr(`MPG_IDX_TH_DIR, 32'hFF, 4'h0);
        rdc(`MPG_IDX_TH_DIR, 32'h0);
        wrr(`MPG_IDX_TH_LATCH, 32'hA5);
        wrr(`MPG_IDX_TH_DIR, 32'hF0);
        idle;
        rdc(`MPG_IDX_TH_LATCH, 32'hAC);
        wrr(`MPG_IDX_OPTION2, 32'h3);
        idle;
        chk(32'(th_pullup_en), 32'h80);
        wrr(8'h0C, 32'hFF);
        rdc(8'h0C, 32'h0, 1'b1);
        rdc(8'h00, 32'h0, 1'b1);
        $display("t_th done");
    endtask
    task t_keep;
        wrr(`MPG_IDX_OD_LATCH, 32'h3C);
        do_reset;
        chk(32'(od_pin_oe_n), 32'hFF);
        wrr(`MPG_IDX_OD_DIR, 32'hFF);
        rdc(`MPG_IDX_OD_LATCH, 32'h3C);
        $display("t_keep done");
    endtask
    task print_verdict;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        do_reset;
        t_reset;
        t_od;
        t_ts;
        t_th;
        t_keep;
        print_verdict;
    end
    initial begin
        #100000;
        miscompares++;
        print_verdict;
    end
endmodule // tb_top
